//--- core/tdc_consts.vh
// Behaviour
// - Luma gain select switches luminance input sensitivity between two ranges.
// - Second RGB input gets brightness only; merged by blending or fast blanking.
// - Fast insertion switches act only when enabled by a control bit.
// - Matrix select: PAL/SECAM, two NTSC variants, and high-definition ATSC.
// - High and low currents measured in alternate fields; leakage every field.
// - Single-point mode regulates black level only; drive level leaves gain alone.
// - Outputs blanked from power-on until loop fail flag first falls to zero.
// - Status shows lowest black level inside, above or below the window.
// - Loop fail flag is set whenever the black current loop fails.
// - Vertical blanking follows field rate; long blank forces 50 Hz length.
// - Blue background is inserted when its enable bit is set.
// - VCO runs at 440 times sync rate double-line, 880 single-line.
// - Free-running VCO calibrated from 12 MHz reference, resonator or external.
// - Line-rate pin grounded or open selects single or double line drive.
// - High-def bit raises free-running drive from 31.2 kHz to 33.7 kHz.
// - Single/double line mode changes are accepted only in standby.
// - Multi-sync mode measures sync frequency and retunes VCO centre via DAC.
// - Horizontal and vertical sync polarities are detected and readable.
// - Second loop phases VCO reference to flyback; shift, parallelogram, bow applied.
// - Missing flyback flag set after three line periods without flyback.
// - Red and green black levels get programmable offsets over loop level.
// - Control bytes live at subaddresses 00 to 1F with auto-increment.
// - Standby is entered or left only when both standby bits change.
`ifndef TDC_CONSTS_VH
`define TDC_CONSTS_VH
`define TDC_VCO_RATIO_DOUBLE   10'h1B8
`define TDC_VCO_RATIO_SINGLE   10'h370
`define TDC_FREE_NORMAL_HZ     32'h0000_79E0
`define TDC_FREE_HD_HZ         32'h0000_83A4
`define TDC_MS_MIN_HZ          32'h0000_7530
`define TDC_MS_MAX_HZ          32'h0000_C350
`define TDC_CLK_HZ             32'h0262_5A00
`define TDC_FLYBACK_MISS_LINES 2'h3
`define TDC_MAT_PAL            2'h0
`define TDC_MAT_NTSC_A         2'h1
`define TDC_MAT_NTSC_B         2'h2
`define TDC_MAT_ATSC           2'h3
`define TDC_VBLANK_50_LINES    8'h16
`define TDC_VBLANK_60_LINES    8'h12
`define TDC_FIELD_50_LINES     16'h0238
`endif

//--- core/tdc_display_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "tdc_consts.vh"
module tdc_display_ctrl (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    // Control bits from the host
    input  wire        luma_gain_select_i,
    input  wire        fast_insert_enable_i,
    input  wire [1:0]  matrix_select_i,
    input  wire        osd_blend_select_i,
    input  wire        single_point_calib_select_i,
    input  wire        long_blank_select_i,
    input  wire        blue_background_enable_i,
    input  wire        high_def_freerun_select_i,
    input  wire        multi_sync_enable_i,
    input  wire        standby_bit_a_i,
    input  wire        standby_bit_b_i,
    input  wire [5:0]  h_shift_i,
    input  wire [5:0]  h_parallelogram_i,
    input  wire [5:0]  h_bow_i,
    input  wire [5:0]  red_black_offset_i,
    input  wire [5:0]  green_black_offset_i,
    // Pins and analog comparator results
    input  wire        hsync_i,
    input  wire        vsync_i,
    input  wire        flyback_i,
    input  wire        line_rate_pin_i,
    input  wire        ext_ref_select_i,
    input  wire        fast_blank_1_i,
    input  wire        fast_blank_2_i,
    input  wire        loop_fail_i,
    input  wire [1:0]  black_level_cmp_i,
    // Control outputs to the analog path
    output reg         luma_range_high_o,
    output reg  [1:0]  matrix_o,
    output reg         rgb1_insert_o,
    output reg         osd_insert_o,
    output reg         osd_blend_o,
    output reg         osd_brightness_only_o,
    output reg         gain_loop_enable_o,
    output reg  [1:0]  measure_phase_o,
    output reg         leakage_measure_o,
    output reg         rgb_blank_o,
    output reg         vblank_o,
    output reg         blue_background_o,
    output reg  [9:0]  vco_ratio_o,
    output reg  [15:0] vco_centre_khz_o,
    output reg         ref_external_o,
    output reg         single_line_mode_o,
    output reg         standby_o,
    output reg  [17:0] hdrive_adjust_o,
    output reg  [5:0]  red_offset_o,
    output reg  [5:0]  green_offset_o,
    // Status bits for the host
    output reg         black_loop_fail_flag_o,
    output reg         black_in_window_flag_o,
    output reg         black_above_window_flag_o,
    output reg         hsync_polarity_flag_o,
    output reg         vsync_polarity_flag_o,
    output reg         missing_flyback_flag_o
);

// ==========================================================================
// Input synchronisers: a change counts once stages two and three agree.
// ==========================================================================
localparam NSYNC = 6;
wire [NSYNC-1:0] raw_in = {hsync_i, vsync_i, flyback_i, line_rate_pin_i,
                           loop_fail_i, fast_blank_2_i};
reg  [NSYNC-1:0] s1;
reg  [NSYNC-1:0] s2;
reg  [NSYNC-1:0] s3;
reg  [NSYNC-1:0] clean;
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        // The loop-fail lane starts at one, its power-on level, so reset
        // never shows a false one-to-zero fall that would lift the blanking.
        s1    <= 6'h02;
        s2    <= 6'h02;
        s3    <= 6'h02;
        clean <= 6'h02;
    end else begin
        s1 <= raw_in;
        s2 <= s1;
        s3 <= s2;
        clean <= (~(s2 ^ s3) & s2) | ((s2 ^ s3) & clean);
    end
end
wire hs_c   = clean[5];
wire vs_c   = clean[4];
wire fb_c   = clean[3];
wire lrp_c  = clean[2];
wire fail_c = clean[1];
wire fb2_c  = clean[0];

// Fast blanking 1 is a mid-line pixel switch; a slow synchroniser is the
// trade made here since the insertion path itself is analog.
reg [2:0] fb1_s;
reg       fb1_c;
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        fb1_s <= 3'h0;
        fb1_c <= 1'b0;
    end else begin
        fb1_s <= {fb1_s[1:0], fast_blank_1_i};
        // Like the other pins, a change counts once stages two and three agree.
        if (fb1_s[1] == fb1_s[2]) fb1_c <= fb1_s[1];
    end
end

// ==========================================================================
// Edge and period tracking.
// ==========================================================================
reg hs_d;
reg vs_d;
reg fb_d;
reg fail_d;
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        hs_d   <= 1'b0;
        vs_d   <= 1'b0;
        fb_d   <= 1'b0;
        fail_d <= 1'b1;
    end else begin
        hs_d   <= hs_c;
        vs_d   <= vs_c;
        fb_d   <= fb_c;
        fail_d <= fail_c;
    end
end
wire hs_rise = hs_c & ~hs_d;
wire vs_rise = vs_c & ~vs_d;
wire fb_rise = fb_c & ~fb_d;

// Line period in clocks and high time, for polarity and frequency.
reg [15:0] h_cnt;
reg [15:0] h_high;
reg [15:0] h_period;
reg [15:0] lines_in_field;
reg [15:0] field_lines;
reg [23:0] v_cnt;
reg [23:0] v_high;
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        h_cnt          <= 16'h0000;
        h_high         <= 16'h0000;
        h_period       <= 16'h0000;
        lines_in_field <= 16'h0000;
        field_lines    <= 16'h0000;
        v_cnt          <= 24'h00_0000;
        v_high         <= 24'h00_0000;
        hsync_polarity_flag_o <= 1'b0;
        vsync_polarity_flag_o <= 1'b0;
    end else begin
        if (hs_rise) begin
            h_cnt    <= 16'h0001;
            h_high   <= 16'h0001;
            h_period <= h_cnt;
            // A pulse high for more than half the period is negative sync.
            hsync_polarity_flag_o <= (h_high > {1'b0, h_cnt[15:1]});
            lines_in_field <= lines_in_field + 16'h0001;
        end else begin
            if (h_cnt != 16'hFFFF) h_cnt <= h_cnt + 16'h0001;
            if (hs_c && h_high != 16'hFFFF) h_high <= h_high + 16'h0001;
        end
        if (vs_rise) begin
            v_cnt  <= 24'h00_0001;
            v_high <= 24'h00_0001;
            vsync_polarity_flag_o <= (v_high > {1'b0, v_cnt[23:1]});
            field_lines    <= lines_in_field;
            lines_in_field <= 16'h0000;
        end else begin
            if (v_cnt != 24'hFF_FFFF) v_cnt <= v_cnt + 24'h00_0001;
            if (vs_c && v_high != 24'hFF_FFFF) v_high <= v_high + 24'h00_0001;
        end
    end
end

// ==========================================================================
// Standby and line-rate mode.
// ==========================================================================
reg sb_a_q;
reg sb_b_q;
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        sb_a_q             <= 1'b0;
        sb_b_q             <= 1'b0;
        standby_o          <= 1'b1;
        single_line_mode_o <= 1'b0;
    end else begin
        // Only a change of both bits counts; a lone change is held off.
        if ((standby_bit_a_i != sb_a_q) && (standby_bit_b_i != sb_b_q)) begin
            sb_a_q    <= standby_bit_a_i;
            sb_b_q    <= standby_bit_b_i;
            standby_o <= ~standby_o;
        end
        // Grounded pin selects single-line drive; open (high) is double-line.
        if (standby_o) single_line_mode_o <= ~lrp_c;
    end
end

// ==========================================================================
// Horizontal oscillator settings.
// ==========================================================================
// Measured sync rate in Hz; divide done once per line, fine at line rate.
wire [31:0] meas_hz = (h_period == 16'h0000) ? 32'h0000_0000
                      : (`TDC_CLK_HZ / {16'h0000, h_period});
// Centre settings are divided at full width and cut to the output on purpose.
wire [31:0] meas_khz    = meas_hz / 32'h0000_03E8;
wire [31:0] ms_min_khz  = `TDC_MS_MIN_HZ / 32'h0000_03E8;
wire [31:0] ms_max_khz  = `TDC_MS_MAX_HZ / 32'h0000_03E8;
wire [31:0] free_hd     = `TDC_FREE_HD_HZ / 32'h0000_0064;
wire [31:0] free_normal = `TDC_FREE_NORMAL_HZ / 32'h0000_0064;
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        vco_ratio_o      <= 10'h000;
        vco_centre_khz_o <= 16'h0000;
        ref_external_o   <= 1'b0;
        hdrive_adjust_o  <= 18'h0_0000;
    end else begin
        vco_ratio_o <= single_line_mode_o ? `TDC_VCO_RATIO_SINGLE
                                          : `TDC_VCO_RATIO_DOUBLE;
        ref_external_o <= ext_ref_select_i;
        if (multi_sync_enable_i) begin
            if (meas_hz < `TDC_MS_MIN_HZ)
                vco_centre_khz_o <= ms_min_khz[15:0];
            else if (meas_hz > `TDC_MS_MAX_HZ)
                vco_centre_khz_o <= ms_max_khz[15:0];
            else
                vco_centre_khz_o <= meas_khz[15:0];
        end else if (high_def_freerun_select_i) begin
            vco_centre_khz_o <= free_hd[15:0];
        end else begin
            vco_centre_khz_o <= free_normal[15:0];
        end
        hdrive_adjust_o <= {h_bow_i, h_parallelogram_i, h_shift_i};
    end
end

// ==========================================================================
// Flyback supervision.
// ==========================================================================
reg [1:0] miss_cnt;
reg       fb_seen;
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        miss_cnt <= 2'h0;
        fb_seen  <= 1'b0;
        missing_flyback_flag_o <= 1'b0;
    end else begin
        if (hs_rise) begin
            fb_seen <= fb_rise;
            if (fb_seen || fb_rise) begin
                miss_cnt <= 2'h0;
                missing_flyback_flag_o <= 1'b0;
            end else if (miss_cnt == `TDC_FLYBACK_MISS_LINES - 2'h1) begin
                miss_cnt <= `TDC_FLYBACK_MISS_LINES;
                missing_flyback_flag_o <= 1'b1;
            end else if (miss_cnt != `TDC_FLYBACK_MISS_LINES) begin
                miss_cnt <= miss_cnt + 2'h1;
            end
        end else if (fb_rise) begin
            fb_seen <= 1'b1;
        end
    end
end

// ==========================================================================
// Black current loop, RGB blanking and vertical blanking.
// ==========================================================================
reg        blank_released;
reg [15:0] vb_cnt;
// The length is taken at field start, so a select change waits a field.
wire [7:0] vb_len = (long_blank_select_i || field_lines >= `TDC_FIELD_50_LINES)
                    ? `TDC_VBLANK_50_LINES : `TDC_VBLANK_60_LINES;
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        blank_released  <= 1'b0;
        rgb_blank_o     <= 1'b1;
        measure_phase_o <= 2'h0;
        leakage_measure_o <= 1'b0;
        vb_cnt          <= 16'h0000;
        vblank_o        <= 1'b0;
        black_loop_fail_flag_o    <= 1'b1;
        black_in_window_flag_o    <= 1'b0;
        black_above_window_flag_o <= 1'b0;
        gain_loop_enable_o <= 1'b1;
    end else begin
        black_loop_fail_flag_o <= fail_c;
        // Released only on the first one-to-zero fall; later failures
        // stay visible in the flag and are left to host policy.
        if (fail_d && !fail_c) blank_released <= 1'b1;
        rgb_blank_o <= ~(blank_released | (fail_d & ~fail_c));
        black_in_window_flag_o    <= black_level_cmp_i == 2'h0;
        black_above_window_flag_o <= black_level_cmp_i == 2'h1;
        gain_loop_enable_o <= ~single_point_calib_select_i;
        if (vs_rise) begin
            // Bit 1 low: high current field; high: low current field.
            measure_phase_o <= single_point_calib_select_i ? 2'h0
                               : {~measure_phase_o[1], 1'b1};
            leakage_measure_o <= 1'b1;
        end else if (hs_rise) begin
            leakage_measure_o <= 1'b0;
        end
        if (vs_rise) begin
            vb_cnt   <= {8'h00, vb_len};
            vblank_o <= 1'b1;
        end else if (hs_rise && vb_cnt != 16'h0000) begin
            vb_cnt <= vb_cnt - 16'h0001;
            if (vb_cnt == 16'h0001) vblank_o <= 1'b0;
        end
    end
end

// ==========================================================================
// Video path selection and black offsets.
// ==========================================================================
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        luma_range_high_o     <= 1'b0;
        matrix_o              <= `TDC_MAT_PAL;
        rgb1_insert_o         <= 1'b0;
        osd_insert_o          <= 1'b0;
        osd_blend_o           <= 1'b0;
        osd_brightness_only_o <= 1'b1;
        blue_background_o     <= 1'b0;
        red_offset_o          <= 6'h00;
        green_offset_o        <= 6'h00;
    end else begin
        luma_range_high_o <= luma_gain_select_i;
        matrix_o          <= matrix_select_i;
        rgb1_insert_o     <= fast_insert_enable_i & fb1_c;
        osd_insert_o      <= fast_insert_enable_i & fb2_c;
        osd_blend_o       <= osd_blend_select_i;
        osd_brightness_only_o <= 1'b1;
        blue_background_o <= blue_background_enable_i;
        red_offset_o      <= red_black_offset_i;
        green_offset_o    <= green_black_offset_i;
    end
end

endmodule // tdc_display_ctrl
`default_nettype wire

//--- verif/tdc_display_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port checker for the display control block.
module tdc_mon (
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    // Inputs watched
    input wire logic        fast_insert_enable_i,
    input wire logic        single_point_calib_select_i,
    input wire logic        high_def_freerun_select_i,
    input wire logic        multi_sync_enable_i,
    input wire logic [5:0]  h_shift_i,
    input wire logic [5:0]  h_parallelogram_i,
    input wire logic [5:0]  h_bow_i,
    input wire logic [5:0]  red_black_offset_i,
    input wire logic [5:0]  green_black_offset_i,
    input wire logic        loop_fail_i,
    input wire logic [1:0]  black_level_cmp_i,
    // Outputs watched
    input wire logic        rgb1_insert_o,
    input wire logic        gain_loop_enable_o,
    input wire logic [1:0]  measure_phase_o,
    input wire logic        rgb_blank_o,
    input wire logic [9:0]  vco_ratio_o,
    input wire logic [15:0] vco_centre_khz_o,
    input wire logic        single_line_mode_o,
    input wire logic        standby_o,
    input wire logic [17:0] hdrive_adjust_o,
    input wire logic [5:0]  red_offset_o,
    input wire logic [5:0]  green_offset_o,
    input wire logic        black_loop_fail_flag_o,
    input wire logic        black_in_window_flag_o,
    input wire logic        black_above_window_flag_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    blank_hold_a: assert property (!rgb_blank_o |=> !rgb_blank_o)
        else $error("RGB blanking returned after release");
    insert_gate_a: assert property (!fast_insert_enable_i [*2] |-> !rgb1_insert_o)
        else $error("Fast insertion acted while disabled");
    single_pt_a: assert property (single_point_calib_select_i |=>
        measure_phase_o == 2'h0 && !gain_loop_enable_o)
        else $error("Gain loop active in single-point mode");
    window_a: assert property ((black_level_cmp_i == 2'h0) [*2] |->
        black_in_window_flag_o && !black_above_window_flag_o)
        else $error("In-window flag wrong");
    above_a: assert property ((black_level_cmp_i == 2'h1) [*2] |->
        black_above_window_flag_o && !black_in_window_flag_o)
        else $error("Above-window flag wrong");
    fail_flag_a: assert property ($stable(loop_fail_i) [*8] |->
        black_loop_fail_flag_o == loop_fail_i)
        else $error("Loop fail flag does not follow the loop");
    centre_a: assert property ((!multi_sync_enable_i && $stable(high_def_freerun_select_i)) [*2]
        |-> vco_centre_khz_o == (high_def_freerun_select_i ? 16'h0151 : 16'h0138))
        else $error("Free-running frequency wrong");
    ratio_a: assert property ($stable(single_line_mode_o) [*2] |->
        vco_ratio_o == (single_line_mode_o ? 10'h370 : 10'h1B8))
        else $error("VCO ratio does not match line mode");
    line_lock_a: assert property (!standby_o [*2] |-> $stable(single_line_mode_o))
        else $error("Line mode changed outside standby");
    hdrive_a: assert property (1'b1 |=>
        hdrive_adjust_o == $past({h_bow_i, h_parallelogram_i, h_shift_i}))
        else $error("Horizontal drive adjust not applied");
    offset_a: assert property (1'b1 |=>
        {red_offset_o, green_offset_o} == $past({red_black_offset_i, green_black_offset_i}))
        else $error("Black offsets not applied");

    cover property (rgb_blank_o ##1 !rgb_blank_o);
    cover property ($rose(standby_o));
    cover property ($changed(single_line_mode_o));
endmodule // tdc_mon
`default_nettype wire

//--- verif/tdc_sync_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Input processor and flyback source: one line every LINE clocks.
module tdc_sync_src #(
    parameter int LINE = 64
) (
    input  wire logic clk_i,
    input  wire logic fly_en_i,
    input  wire logic inv_i,
    output var  logic hsync_o,
    output var  logic flyback_o
);
    int cnt = 0;
    always @(posedge clk_i) begin
        cnt <= (cnt == LINE - 1) ? 0 : cnt + 1;
    end
    // Inverting the short pulse models a source with negative-going sync.
    assign hsync_o = (cnt < 4) ^ inv_i;
    // Dropping fly_en_i models a deflection stage that stopped returning pulses.
    assign flyback_o = fly_en_i && cnt >= 20 && cnt < 28;
endmodule // tdc_sync_src
`default_nettype wire

//--- verif/test_tv_display_control_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_tv_display_control_status;
    // ======================================================================
    // Signals carry the block's port names so the instance binds by name.
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic luma_gain_select_i, fast_insert_enable_i, osd_blend_select_i, long_blank_select_i;
    logic single_point_calib_select_i, blue_background_enable_i, high_def_freerun_select_i;
    logic multi_sync_enable_i, standby_bit_a_i, standby_bit_b_i, vsync_i, line_rate_pin_i;
    logic ext_ref_select_i, fast_blank_1_i, fast_blank_2_i, loop_fail_i, fly_en, sync_inv, m0;
    logic [1:0] matrix_select_i, black_level_cmp_i;
    logic [5:0] h_shift_i, h_parallelogram_i, h_bow_i, red_black_offset_i, green_black_offset_i;
    wire logic hsync_i, flyback_i, luma_range_high_o, rgb1_insert_o, osd_insert_o, osd_blend_o;
    wire logic osd_brightness_only_o, gain_loop_enable_o, leakage_measure_o, rgb_blank_o;
    wire logic vblank_o, blue_background_o, ref_external_o, single_line_mode_o, standby_o;
    wire logic black_loop_fail_flag_o, black_in_window_flag_o, black_above_window_flag_o;
    wire logic hsync_polarity_flag_o, vsync_polarity_flag_o, missing_flyback_flag_o;
    wire logic [1:0] matrix_o, measure_phase_o;
    wire logic [9:0] vco_ratio_o;
    wire logic [15:0] vco_centre_khz_o;
    wire logic [17:0] hdrive_adjust_o;
    wire logic [5:0] red_offset_o, green_offset_o;
    int n_errors = 0;
    int checks = 0;

    tdc_display_ctrl dut (.*);
    tdc_sync_src src (.clk_i(clk_sys_i), .fly_en_i(fly_en), .inv_i(sync_inv),
                      .hsync_o(hsync_i), .flyback_o(flyback_i));

    always #12.5 clk_sys_i = ~clk_sys_i;

    task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task complete_run;
        $display("Checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic t_power_on;
        chk("standby", standby_o, 1'b1);
        idle(30);
        chk("blank", rgb_blank_o, 1'b1);
        loop_fail_i = 1'b0;
        idle(12);
        chk("fail", black_loop_fail_flag_o, 1'b0);
        chk("blank", rgb_blank_o, 1'b0);
        loop_fail_i = 1'b1;
        idle(12);
        chk("fail", black_loop_fail_flag_o, 1'b1);
        chk("blank", rgb_blank_o, 1'b0);
        loop_fail_i = 1'b0;
    endtask

    task automatic t_controls;
        for (int i = 0; i < 4; i++) begin
            matrix_select_i = i[1:0];
            luma_gain_select_i = i[0];
            osd_blend_select_i = i[0];
            blue_background_enable_i = i[1];
            ext_ref_select_i = ~i[0];
            idle(2);
            chk("matrix", matrix_o, i[1:0]);
            chk("luma", luma_range_high_o, i[0]);
            chk("blend", osd_blend_o, i[0]);
            chk("bright", osd_brightness_only_o, 1'b1);
            chk("blue", blue_background_o, i[1]);
            chk("ref", ref_external_o, !i[0]);
        end
        {h_bow_i, h_parallelogram_i, h_shift_i} = 18'h3_F801;
        {red_black_offset_i, green_black_offset_i} = 12'hA95;
        single_point_calib_select_i = 1'b1;
        idle(2);
        chk("hdrive", hdrive_adjust_o, 18'h3_F801);
        chk("offset", {red_offset_o, green_offset_o}, 12'hA95);
        chk("gain", gain_loop_enable_o, 1'b0);
        single_point_calib_select_i = 1'b0;
        {fast_blank_1_i, fast_blank_2_i} = 2'b11;
        idle(8);
        chk("insert", rgb1_insert_o, 1'b0);
        chk("osd", osd_insert_o, 1'b0);
        fast_insert_enable_i = 1'b1;
        idle(8);
        chk("insert", rgb1_insert_o, 1'b1);
        chk("osd", osd_insert_o, 1'b1);
        fast_insert_enable_i = 1'b0;
        for (int k = 0; k < 3; k++) begin
            black_level_cmp_i = k[1:0];
            idle(3);
            chk("window", black_in_window_flag_o, k == 0);
            chk("above", black_above_window_flag_o, k == 1);
        end
    endtask

    task automatic t_line_rate;
        m0 = single_line_mode_o;
        line_rate_pin_i = ~line_rate_pin_i;
        idle(10);
        chk("mode", single_line_mode_o, !m0);
        chk("ratio", vco_ratio_o, m0 ? 10'h1B8 : 10'h370);
        standby_bit_a_i = 1'b1;
        idle(4);
        chk("standby", standby_o, 1'b1);
        standby_bit_b_i = 1'b1;
        idle(4);
        chk("standby", standby_o, 1'b0);
        line_rate_pin_i = ~line_rate_pin_i;
        idle(10);
        chk("mode", single_line_mode_o, !m0);
        standby_bit_b_i = 1'b0;
        idle(4);
        chk("standby", standby_o, 1'b0);
        standby_bit_a_i = 1'b0;
        idle(10);
        chk("mode", single_line_mode_o, m0);
    endtask

    task automatic t_hsync;
        high_def_freerun_select_i = 1'b1;
        idle(2);
        chk("centre", vco_centre_khz_o, 16'h0151);
        high_def_freerun_select_i = 1'b0;
        multi_sync_enable_i = 1'b1;
        idle(600);
        chk("centre", vco_centre_khz_o, 16'h0032);
        multi_sync_enable_i = 1'b0;
        chk("hsync_polarity_flag", hsync_polarity_flag_o, 1'b0);
        sync_inv = 1'b1;
        idle(400);
        chk("hsync_polarity_flag", hsync_polarity_flag_o, 1'b1);
        sync_inv = 1'b0;
        idle(300);
        chk("nofly", missing_flyback_flag_o, 1'b0);
        @(posedge hsync_i);
        idle(1);
        fly_en = 1'b0;
        idle(160);
        chk("nofly", missing_flyback_flag_o, 1'b0);
        idle(70);
        chk("nofly", missing_flyback_flag_o, 1'b1);
        fly_en = 1'b1;
        idle(200);
        chk("nofly", missing_flyback_flag_o, 1'b0);
    endtask

    // A field pulse starts on a line start; inv selects negative-going sync.
    task automatic pulse_vsync(input logic inv);
        @(posedge hsync_i);
        idle(1);
        vsync_i = ~inv;
        idle(8);
        vsync_i = inv;
    endtask

    task automatic t_vsync;
        logic [1:0] mp;
        for (int f = 0; f < 2; f++) begin
            long_blank_select_i = f[0];
            pulse_vsync(1'b0);
            if (f == 1) chk("phase", measure_phase_o, {~mp[1], 1'b1});
            mp = measure_phase_o;
            chk("phase0", mp[0], 1'b1);
            chk("leak", leakage_measure_o, 1'b1);
            repeat (f ? 21 : 17) @(posedge hsync_i);
            idle(10);
            chk("leak", leakage_measure_o, 1'b0);
            chk("vblank", vblank_o, 1'b1);
            @(posedge hsync_i);
            idle(10);
            chk("vblank", vblank_o, 1'b0);
        end
        chk("vsync_polarity_flag", vsync_polarity_flag_o, 1'b0);
        repeat (2) pulse_vsync(1'b1);
        idle(8);
        chk("vsync_polarity_flag", vsync_polarity_flag_o, 1'b1);
        vsync_i = 1'b0;
    endtask

    initial begin
        {luma_gain_select_i, fast_insert_enable_i, osd_blend_select_i, long_blank_select_i,
         single_point_calib_select_i, blue_background_enable_i, high_def_freerun_select_i,
         multi_sync_enable_i, standby_bit_a_i, standby_bit_b_i, vsync_i, line_rate_pin_i,
         ext_ref_select_i, fast_blank_1_i, fast_blank_2_i, sync_inv, matrix_select_i,
         black_level_cmp_i, h_shift_i, h_parallelogram_i, h_bow_i, red_black_offset_i,
         green_black_offset_i} = '0;
        loop_fail_i = 1'b1;
        fly_en = 1'b1;
        idle(20);
        rst_n_i = 1'b1;
        t_power_on;
        t_controls;
        t_line_rate;
        t_hsync;
        t_vsync;
        complete_run;
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        complete_run;
    end
endmodule // test_tv_display_control_status

bind tdc_display_ctrl tdc_mon mon (.*);
`default_nettype wire
